/* rtl/sfp_pkg.sv */
package sfp_pkg;
  // ============================================================
  // Frame format
  localparam int WORD_W = 16;
  localparam int FCNT_W = 5;
  localparam int OCNT_W = 4;
  localparam logic [FCNT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [FCNT_W-1:0] LAST_BIT = 5'h0f;
  localparam int NPINS = 8;
  localparam int BUSY_PIN = 7;
  localparam int CODE_W = 12;
  localparam int CHAN_W = 3;

  // ============================================================
  // Command word layout
  localparam int DAC_FLAG_BIT = 15;
  localparam int CMD_HI = 14;
  localparam int CMD_LO = 12;
  localparam int DCH_HI = 14;
  localparam int DCH_LO = 12;
  localparam logic [2:0] CMD_READBACK = 3'h0;
  localparam logic [2:0] CMD_SET_GPI = 3'h1;
  localparam logic [2:0] CMD_SET_GPO = 3'h2;
  localparam logic [2:0] CMD_SET_ADC = 3'h3;
  localparam logic [2:0] CMD_SET_DAC = 3'h4;
  localparam logic [2:0] CMD_GPO_WR = 3'h5;
  localparam logic [2:0] CMD_CTRL = 3'h6;
  localparam logic [2:0] CMD_CONVERT = 3'h7;
  localparam logic [1:0] RB_PIN_IN = 2'h0;
  localparam logic [1:0] RB_GPO = 2'h1;
  localparam logic [1:0] RB_MODES = 2'h2;
  localparam logic [1:0] RB_TEMP = 2'h3;
  localparam int CTRL_BUSY_EN_BIT = 0;

  // ============================================================
  // Reset values
  localparam logic [NPINS-1:0] OE_N_RST = 8'hff;

  // ============================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int CONV_NS = 2000;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_W = 9;

  typedef enum logic [1:0] {PM_GPI, PM_GPO, PM_ADC, PM_DAC} sfp_mode_t;
  typedef enum logic {CV_IDLE, CV_RUN} sfp_cv_t;
endpackage

/* rtl/sfp_if.sv */
`timescale 1ns/1ps
interface sfp_if;
  logic [15:0] rx_word;
  logic done_tgl;
  logic [15:0] tx_word;
  modport link (output rx_word, output done_tgl, input tx_word);
  modport core (input rx_word, input done_tgl, output tx_word);
endinterface

/* rtl/sfp_link.sv */
`timescale 1ns/1ps
module sfp_link
  import sfp_pkg::*;
(
  input wire logic sclk,
  input wire logic nrst,
  input wire logic sync_n,
  input wire logic serial_in,
  output logic serial_out,
  sfp_if.link lk
);
  typedef struct packed {
    logic [FCNT_W-1:0] cnt;
    logic [WORD_W-1:0] sr;
  } sfp_frame_t;
  typedef struct packed {
    logic [WORD_W-1:0] rx;
    logic tgl;
  } sfp_result_t;
  typedef struct packed {
    logic [OCNT_W-1:0] cnt;
  } sfp_out_t;

  sfp_frame_t f_q, f_d;
  sfp_result_t r_q, r_d;
  sfp_out_t o_q, o_d;
  logic frame_rst_n;

  // Frame state lives only while select is low
  assign frame_rst_n = nrst & ~sync_n;

  // ============================================================
  // Input side, falling edges
  always_comb
  begin
    f_d = f_q;
    r_d = r_q;
    if (f_q.cnt < FRAME_BITS)
    begin
      f_d.sr = {f_q.sr[WORD_W-2:0], serial_in};
      f_d.cnt = f_q.cnt + 5'h01;
    end
    if (f_q.cnt == LAST_BIT)
    begin
      r_d.rx = {f_q.sr[WORD_W-2:0], serial_in};
      r_d.tgl = ~r_q.tgl;
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      f_q <= '0;
    else
      f_q <= f_d;
  end

  always_ff @(negedge sclk or negedge nrst)
  begin
    if (!nrst)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  // ============================================================
  // Output side, rising edges follow a falling edge
  always_comb
  begin
    o_d = o_q;
    if (({1'b0, o_q.cnt} < f_q.cnt) && (o_q.cnt != 4'hf))
      o_d.cnt = o_q.cnt + 4'h1;
  end

  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      o_q <= '0;
    else
      o_q <= o_d;
  end

  // MSB shows as soon as select falls, no edge needed
  assign serial_out = lk.tx_word[4'hf - o_q.cnt];
  assign lk.rx_word = r_q.rx;
  assign lk.done_tgl = r_q.tgl;

  // ============================================================
  // Checks
  property p_capture;
    @(negedge sclk) disable iff (!frame_rst_n)
    ($past(f_q.cnt) < FRAME_BITS) && (f_q.cnt != 5'h00) |-> f_q.sr[0] == $past(serial_in);
  endproperty
  a_capture: assert property (p_capture) else $error("serial input bit not captured");

  property p_word_done;
    @(negedge sclk) disable iff (!nrst)
    (f_q.cnt == LAST_BIT) |=> (r_q.tgl != $past(r_q.tgl)) && (r_q.rx[0] == $past(serial_in));
  endproperty
  a_word_done: assert property (p_word_done) else $error("word not completed on edge 16");

  property p_no_partial;
    @(negedge sclk) disable iff (!nrst)
    (r_q.tgl != $past(r_q.tgl)) |-> ($past(f_q.cnt) == LAST_BIT);
  endproperty
  a_no_partial: assert property (p_no_partial) else $error("word handed over early");

  property p_out_shift;
    @(posedge sclk) disable iff (!frame_rst_n)
    (o_q.cnt != $past(o_q.cnt)) |-> ({1'b0, o_q.cnt} <= f_q.cnt);
  endproperty
  a_out_shift: assert property (p_out_shift) else $error("output shifted without fall");
endmodule // sfp_link

/* rtl/sfp_top.sv */
`timescale 1ns/1ps
// What this block does
// - Serial input bits are captured on each falling serial clock edge.
// - Low frame select starts a frame; sixteen falling edges form one word.
// - Asynchronous low reset returns all configuration to defaults.
// - Output word MSB appears on the output line when frame select falls.
// - Next output bit moves on first rising edge after a falling edge.
// - Output line returns conversion results, readback and temperature values.
// - Each of eight pins is analog out, analog in, digital in or out.
// - Eighth pin can show busy while a conversion runs.
module sfp_top
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic [sfp_pkg::NPINS-1:0] config_pins_in,
  output logic [sfp_pkg::NPINS-1:0] config_pins_out,
  output logic [sfp_pkg::NPINS-1:0] config_pins_oe_n,
  output logic [2*sfp_pkg::NPINS-1:0] pin_mode,
  output logic [sfp_pkg::NPINS*sfp_pkg::CODE_W-1:0] dac_code,
  input wire logic [sfp_pkg::CODE_W-1:0] adc_code,
  input wire logic [sfp_pkg::CODE_W-1:0] temp_code,
  output logic adc_start,
  output logic [sfp_pkg::CHAN_W-1:0] adc_chan
);
  import sfp_pkg::*;

  localparam int CONV_MAX = CONV_CYC + 1;

  typedef struct packed {
    logic [2:0] sync_s;
    logic [2:0] tgl_s;
    logic [NPINS-1:0] pin_s0;
    logic [NPINS-1:0] pin_s1;
    sfp_mode_t [NPINS-1:0] mode;
    logic [NPINS-1:0] gpo;
    logic busy_en;
    sfp_cv_t cv;
    logic [CONV_W-1:0] cnt;
    logic [CHAN_W-1:0] chan;
    logic adc_start;
    logic [WORD_W-1:0] tx_pend;
    logic [WORD_W-1:0] tx;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] oe_n;
    logic [NPINS-1:0][CODE_W-1:0] dac;
  } sfp_core_t;

  sfp_core_t q, d;
  logic word_evt;
  logic [WORD_W-1:0] word;
  logic [2:0] cmd;
  logic [CODE_W-1:0] data;

  sfp_if lk ();

  // ============================================================
  // Link side on the serial clock
  sfp_link sfp_link_i (
    .sclk(sclk),
    .nrst(nrst),
    .sync_n(sync_n),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .lk(lk)
  );

  // Word held while select is low, so the link reads it stable
  assign lk.tx_word = q.tx;

  // ============================================================
  // Mode update for every pin whose mask bit is set
  function automatic sfp_mode_t [NPINS-1:0] set_modes(
    input sfp_mode_t [NPINS-1:0] cur,
    input logic [NPINS-1:0] mask,
    input sfp_mode_t m
  );
    sfp_mode_t [NPINS-1:0] r;
    r = cur;
    for (int i = 0; i < NPINS; i++)
    begin
      if (mask[i])
        r[i] = m;
    end
    return r;
  endfunction

  // Completed word arrives as a toggle from the link domain
  assign word_evt = q.tgl_s[1] ^ q.tgl_s[2];
  assign word = lk.rx_word;
  assign cmd = word[CMD_HI:CMD_LO];
  assign data = word[CODE_W-1:0];

  // ============================================================
  // Next state
  always_comb
  begin
    d = q;
    d.sync_s = {q.sync_s[1:0], sync_n};
    d.tgl_s = {q.tgl_s[1:0], lk.done_tgl};
    d.pin_s0 = config_pins_in;
    d.pin_s1 = q.pin_s0;
    d.adc_start = 1'b0;

    unique case (q.cv)
      CV_IDLE:
      begin
        d.cnt = q.cnt;
      end
      CV_RUN:
      begin
        if (q.cnt == '0)
        begin
          d.cv = CV_IDLE;
          d.tx_pend = {1'b0, q.chan, adc_code};
        end
        else
          d.cnt = q.cnt - 9'h001;
      end
    endcase

    if (word_evt)
    begin
      if (word[DAC_FLAG_BIT])
        d.dac[word[DCH_HI:DCH_LO]] = data;
      else
      begin
        unique case (cmd)
          CMD_READBACK:
          begin
            unique case (data[1:0])
              RB_PIN_IN: d.tx_pend = {8'h00, q.pin_s1};
              RB_GPO: d.tx_pend = {8'h00, q.gpo};
              RB_MODES: d.tx_pend = q.mode;
              RB_TEMP: d.tx_pend = {4'h0, temp_code};
            endcase
          end
          CMD_SET_GPI: d.mode = set_modes(q.mode, data[NPINS-1:0], PM_GPI);
          CMD_SET_GPO: d.mode = set_modes(q.mode, data[NPINS-1:0], PM_GPO);
          CMD_SET_ADC: d.mode = set_modes(q.mode, data[NPINS-1:0], PM_ADC);
          CMD_SET_DAC: d.mode = set_modes(q.mode, data[NPINS-1:0], PM_DAC);
          CMD_GPO_WR: d.gpo = data[NPINS-1:0];
          CMD_CTRL: d.busy_en = data[CTRL_BUSY_EN_BIT];
          CMD_CONVERT:
          begin
            // Only pins set as analog inputs convert
            if ((q.cv == CV_IDLE) && (q.mode[data[CHAN_W-1:0]] == PM_ADC))
            begin
              d.cv = CV_RUN;
              d.cnt = CONV_W'(CONV_CYC - 1);
              d.chan = data[CHAN_W-1:0];
              d.adc_start = 1'b1;
            end
          end
        endcase
      end
    end

    // Refresh outgoing word only between frames
    if (q.sync_s[1])
      d.tx = q.tx_pend;

    // Pin drivers
    for (int i = 0; i < NPINS; i++)
    begin
      d.oe_n[i] = (q.mode[i] != PM_GPO);
      d.pin_out[i] = q.gpo[i];
    end
    if (q.busy_en)
    begin
      d.oe_n[BUSY_PIN] = 1'b0;
      d.pin_out[BUSY_PIN] = (q.cv == CV_RUN);
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.oe_n <= OE_N_RST;
    end
    else
      q <= d;
  end

  assign config_pins_out = q.pin_out;
  assign config_pins_oe_n = q.oe_n;
  assign pin_mode = q.mode;
  assign dac_code = q.dac;
  assign adc_start = q.adc_start;
  assign adc_chan = q.chan;

  // ============================================================
  // Checks
  property p_busy_hold;
    @(posedge clock) disable iff (!nrst)
    $rose(q.cv == CV_RUN) |-> (q.cv == CV_RUN) [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped too early");

  property p_busy_end;
    @(posedge clock) disable iff (!nrst)
    $rose(q.cv == CV_RUN) |-> ##[1:CONV_MAX] (q.cv == CV_IDLE);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("conversion never ended");

  property p_busy_pin;
    @(posedge clock) disable iff (!nrst)
    $past(q.busy_en) |-> (q.pin_out[BUSY_PIN] == $past(q.cv == CV_RUN)) && !q.oe_n[BUSY_PIN];
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy pin does not follow");

  property p_gpo_write;
    @(posedge clock) disable iff (!nrst)
    word_evt && !word[DAC_FLAG_BIT] && (cmd == CMD_GPO_WR) |=> q.gpo == $past(data[NPINS-1:0]);
  endproperty
  a_gpo_write: assert property (p_gpo_write) else $error("output word not applied");

  property p_pin_drive;
    @(posedge clock) disable iff (!nrst)
    !$past(q.busy_en) |-> q.oe_n[BUSY_PIN] == ($past(q.mode[BUSY_PIN]) != PM_GPO);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin drive wrong for mode");

  property p_quiet;
    @(posedge clock) disable iff (!nrst)
    !word_evt && ($past(q.cv) == CV_IDLE) && (q.cv == CV_IDLE) |=> $stable(q.mode) && $stable(q.gpo);
  endproperty
  a_quiet: assert property (p_quiet) else $error("config changed without a word");

  property p_start_pulse;
    @(posedge clock) disable iff (!nrst)
    q.adc_start |=> !q.adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");

  property p_start_run;
    @(posedge clock) disable iff (!nrst)
    q.adc_start |-> (q.cv == CV_RUN) && (q.cnt == CONV_W'(CONV_CYC - 1));
  endproperty
  a_start_run: assert property (p_start_run) else $error("start without busy");

  property p_conv_count;
    @(posedge clock) disable iff (!nrst)
    (q.cv == CV_RUN) && (q.cnt != '0)
      |=> (q.cv == CV_RUN) && (q.cnt == $past(q.cnt) - 9'h001);
  endproperty
  a_conv_count: assert property (p_conv_count) else $error("busy count skipped");

  property p_conv_result;
    @(posedge clock) disable iff (!nrst)
    (q.cv == CV_RUN) && (q.cnt == '0) && !word_evt
      |=> (q.cv == CV_IDLE) && (q.tx_pend == {1'b0, $past(q.chan), $past(adc_code)});
  endproperty
  a_conv_result: assert property (p_conv_result) else $error("result not loaded");

  property p_dac_write;
    @(posedge clock) disable iff (!nrst)
    word_evt && word[DAC_FLAG_BIT] |=> q.dac[$past(word[DCH_HI:DCH_LO])] == $past(data);
  endproperty
  a_dac_write: assert property (p_dac_write) else $error("analog code lost");

  property p_gpo_drive;
    @(posedge clock) disable iff (!nrst)
    ($past(q.mode[0]) == PM_GPO) |-> !q.oe_n[0] && (q.pin_out[0] == $past(q.gpo[0]));
  endproperty
  a_gpo_drive: assert property (p_gpo_drive) else $error("output pin not driven");

  property p_analog_float;
    @(posedge clock) disable iff (!nrst)
    ($past(q.mode[4]) == PM_ADC) || ($past(q.mode[4]) == PM_DAC) |-> q.oe_n[4];
  endproperty
  a_analog_float: assert property (p_analog_float) else $error("analog pin driven");

  property p_tx_load;
    @(posedge clock) disable iff (!nrst)
    q.sync_s[1] |=> q.tx == $past(q.tx_pend);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("out word not refreshed");

  property p_tx_hold;
    @(posedge clock) disable iff (!nrst)
    !q.sync_s[1] |=> $stable(q.tx);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("out word moved in frame");

  property p_temp_read;
    @(posedge clock) disable iff (!nrst)
    word_evt && !word[DAC_FLAG_BIT] && (cmd == CMD_READBACK) && (data[1:0] == RB_TEMP)
      |=> q.tx_pend == {4'h0, $past(temp_code)};
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("temperature not loaded");

  property p_convert_busy;
    @(posedge clock) disable iff (!nrst)
    word_evt && !word[DAC_FLAG_BIT] && (cmd == CMD_CONVERT) && (q.cv == CV_RUN)
      |=> !q.adc_start;
  endproperty
  a_convert_busy: assert property (p_convert_busy) else $error("restart while busy");

  property p_convert_mode;
    @(posedge clock) disable iff (!nrst)
    word_evt && !word[DAC_FLAG_BIT] && (cmd == CMD_CONVERT)
      && (q.mode[data[CHAN_W-1:0]] != PM_ADC) |=> !q.adc_start;
  endproperty
  a_convert_mode: assert property (p_convert_mode) else $error("start on wrong pin");
endmodule // sfp_top

/* tb/sfp_host.sv */
`timescale 1ns/1ps
module sfp_host
(
  output logic sclk,
  output logic sync_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial
  begin
    sclk = 1'b0;
    sync_n = 1'b1;
    serial_in = 1'b0;
  end

  // ============================================================
  // One frame, MSB first, 64 ns serial clock stopped between frames
  task automatic frame(input logic [15:0] w, input int nbits, input logic idle_hi,
                       output logic [15:0] rd);
    rd = 16'h0000;
    sclk = idle_hi;
    #16;
    sync_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      serial_in = w[15-i];
      #16;
      if (!idle_hi) sclk = 1'b1;
      #16;
      rd[15-i] = serial_out;
      sclk = 1'b0;
      #16;
      if (idle_hi) sclk = 1'b1;
      #16;
    end
    sync_n = 1'b1;
    // Released data line shows the inverse of its last value
    serial_in = ~serial_in;
    #100;
  endtask
endmodule // sfp_host

/* tb/sfp_top_bench.sv */
`timescale 1ns/1ps
module sfp_top_bench;
  import sfp_pkg::*;
  logic clock;
  logic nrst;
  logic sclk;
  logic sync_n;
  logic serial_in;
  logic serial_out;
  logic [NPINS-1:0] config_pins_in;
  logic [NPINS-1:0] config_pins_out;
  logic [NPINS-1:0] config_pins_oe_n;
  logic [2*NPINS-1:0] pin_mode;
  logic [NPINS*CODE_W-1:0] dac_code;
  logic [CODE_W-1:0] adc_code;
  logic [CODE_W-1:0] temp_code;
  logic adc_start;
  logic [CHAN_W-1:0] adc_chan;
  logic [15:0] rd;
  int bad_count;
  int n_tests;
  int n_start = 0;

  sfp_top sfp_top_i (.clock(clock), .nrst(nrst), .sclk(sclk), .sync_n(sync_n),
    .serial_in(serial_in), .serial_out(serial_out), .config_pins_in(config_pins_in),
    .config_pins_out(config_pins_out), .config_pins_oe_n(config_pins_oe_n),
    .pin_mode(pin_mode), .dac_code(dac_code), .adc_code(adc_code),
    .temp_code(temp_code), .adc_start(adc_start), .adc_chan(adc_chan));

  sfp_host sfp_host_i (.sclk(sclk), .sync_n(sync_n), .serial_in(serial_in),
    .serial_out(serial_out));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (adc_start === 1'b1) n_start <= n_start + 1;
  end

  // ============================================================
  // Helpers
  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [15:0] w);
    sfp_host_i.frame(w, 16, 1'b0, rd);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task automatic apply_reset;
    @(posedge clock) nrst <= 1'b0;
    repeat (20) @(posedge clock);
    check("oe_n in reset", config_pins_oe_n, 8'hff);
    check("mode in reset", pin_mode, 16'h0000);
    check("out in reset", config_pins_out, 8'h00);
    check("sdo in reset", serial_out, 1'b0);
    @(posedge clock) nrst <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  task automatic t_gpo;
    send(16'h200f);
    send(16'h50a5);
    check("gpo out", config_pins_out, 8'ha5);
    check("gpo oe_n", config_pins_oe_n, 8'hf0);
  endtask

  task automatic t_partial;
    sfp_host_i.frame(16'h50ff, 15, 1'b0, rd);
    check("cut frame", config_pins_out, 8'ha5);
  endtask

  task automatic t_modes;
    send(16'h3010);
    send(16'h4020);
    send(16'hdabc);
    send(16'h1008);
    send(16'h4080);
    check("modes", pin_mode, 16'hce15);
    check("mode oe_n", config_pins_oe_n, 8'hf8);
    check("dac pin5", dac_code[5*CODE_W +: CODE_W], 12'habc);
  endtask

  task automatic t_temp;
    send(16'h0003);
    sfp_host_i.frame(16'h0000, 16, 1'b1, rd);
    check("temp readback", rd, {4'h0, temp_code});
    sfp_host_i.frame(16'h0001, 16, 1'b0, rd);
    check("pin readback", rd, 16'h0096);
    sfp_host_i.frame(16'h0002, 16, 1'b1, rd);
    check("gpo readback", rd, 16'h00a5);
    sfp_host_i.frame(16'h0000, 16, 1'b0, rd);
    check("mode readback", rd, 16'hce15);
  endtask

  task automatic t_convert;
    int n0;
    send(16'h6001);
    check("busy pin driven", config_pins_oe_n[BUSY_PIN], 1'b0);
    check("busy idle", config_pins_out[BUSY_PIN], 1'b0);
    n0 = n_start;
    send(16'h7004);
    check("start pulses", n_start - n0, 1);
    check("chan", adc_chan, 3'h4);
    check("busy high", config_pins_out[BUSY_PIN], 1'b1);
    send(16'h7004);
    check("no restart", n_start - n0, 1);
    check("still busy", config_pins_out[BUSY_PIN], 1'b1);
    repeat (500) @(posedge clock);
    @(negedge clock);
    check("busy low", config_pins_out[BUSY_PIN], 1'b0);
    send(16'h7005);
    check("no start on dac pin", n_start - n0, 1);
    sfp_host_i.frame(16'h0000, 16, 1'b0, rd);
    check("result", rd, {1'b0, 3'h4, adc_code});
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    bad_count = 0;
    n_tests = 0;
    nrst = 1'b0;
    config_pins_in = 8'h96;
    adc_code = 12'h5c3;
    temp_code = 12'h3a7;
    apply_reset();
    t_gpo();
    t_partial();
    t_modes();
    t_temp();
    t_convert();
    apply_reset();
    give_verdict();
  end

  initial
  begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule // sfp_top_bench
